// ==== logic/pbh_budget_table.sv ====
// power budget data words, selected by index
// assumes the table is fixed at elaboration
`timescale 1ns/1ps
`default_nettype none
module pbh_budget_table #(
   parameter int                        N     = pbh_pkg::BUDGET_WORDS,
   parameter pbh_pkg::pbh_budget_table_t TABLE = pbh_pkg::BUDGET_RST
) (
   input  wire logic [7:0]               sel,
   output var pbh_pkg::pbh_budget_word_t word
);
   generate
      if (N != pbh_pkg::BUDGET_WORDS) begin : g_bad_depth
         $error("pbh_budget_table: N must equal the table depth");
      end
   endgenerate

   // pure lookup, so a read disturbs nothing; sub-state is forced to the default
   always_comb begin
      word = '0;
      if (sel < 8'(N)) begin
         word           = TABLE[sel[2:0]];
         word.sub_state = pbh_pkg::SUBSTATE_DEF;
         word.rsvd      = '0;
      end
   end
endmodule // pbh_budget_table
`default_nettype wire

// ==== logic/pbh_interval_timer.sv ====
// interval timer: counts core clocks while a condition holds
// assumes run and limit are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pbh_interval_timer #(
   parameter int W = 24
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   output logic              done
);
   logic [W-1:0] cnt_ff;

   generate
      if (W < 2) begin : g_bad_width
         $error("pbh_interval_timer: W must be at least 2");
      end
   endgenerate

   // restarts whenever the condition drops; saturates so done stays up
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt_ff <= '0;
      end else if (cnt_ff < limit) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign done = run && (cnt_ff >= limit);
endmodule // pbh_interval_timer
`default_nettype wire

// ==== logic/pbh_pkg.sv ====
// power budget / hot-plug user configuration: shared constants and types
// assumes a single core clock at CLK_KHZ and byte addresses on the register bus
package pbh_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int CLK_KHZ          = 40000;
   localparam int NS_PER_MS        = 1000000;
   localparam int L0S_SHORT_NS     = 1000;
   localparam int L0S_LONG_NS      = 4000;
   localparam int L1_SHORT_NS      = 2000;
   localparam int L1_LONG_NS       = 3000;
   // least times round up to whole cycles
   localparam int L0S_SHORT_CYC    = (L0S_SHORT_NS * CLK_KHZ + NS_PER_MS - 1) / NS_PER_MS;
   localparam int L0S_LONG_CYC     = (L0S_LONG_NS * CLK_KHZ + NS_PER_MS - 1) / NS_PER_MS;
   localparam int L1_SHORT_CYC     = (L1_SHORT_NS * CLK_KHZ + NS_PER_MS - 1) / NS_PER_MS;
   localparam int L1_LONG_CYC      = (L1_LONG_NS * CLK_KHZ + NS_PER_MS - 1) / NS_PER_MS;
   localparam int PEPV_BASE_MS     = 16;
   localparam int PVPERL_SHORT_MS  = 20;
   localparam int PVPERL_LONG_MS   = 100;
   localparam int PEPV_BASE_CYC    = PEPV_BASE_MS * CLK_KHZ;
   localparam int PVPERL_SHORT_CYC = PVPERL_SHORT_MS * CLK_KHZ;
   localparam int PVPERL_LONG_CYC  = PVPERL_LONG_MS * CLK_KHZ;
   localparam int TMR_W            = 24;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int          ADDR_W       = 9;
   localparam logic [8:0]  OFS_DATA_SEL = 9'h13C;
   localparam logic [8:0]  OFS_DATA     = 9'h140;
   localparam logic [8:0]  OFS_ALLOC    = 9'h144;
   localparam logic [8:0]  OFS_USER_CFG = 9'h1E0;
   localparam logic [8:0]  OFS_STATUS   = 9'h1E4;
   localparam int          BUDGET_WORDS = 8;

   // ****************************************
   // field layouts and codes
   // ****************************************
   localparam logic [1:0] SCALE_1      = 2'h0;
   localparam logic [1:0] SCALE_0P1    = 2'h1;
   localparam logic [1:0] SCALE_0P01   = 2'h2;
   localparam logic [1:0] SCALE_0P001  = 2'h3;
   localparam logic [2:0] SUBSTATE_DEF = 3'h0;
   localparam logic [1:0] PM_D0        = 2'h0;
   localparam logic [1:0] PM_D3        = 2'h3;
   localparam logic [2:0] COND_PME_AUX = 3'h0;
   localparam logic [2:0] COND_AUX     = 3'h1;
   localparam logic [2:0] COND_IDLE    = 3'h2;
   localparam logic [2:0] COND_SUST    = 3'h3;
   localparam logic [2:0] COND_MAX     = 3'h7;
   localparam logic [2:0] RAIL_12V     = 3'h0;
   localparam logic [2:0] RAIL_3V3     = 3'h1;
   localparam logic [2:0] RAIL_1V8     = 3'h2;
   localparam logic [2:0] RAIL_THERMAL = 3'h7;

   typedef struct packed {
      logic [10:0] rsvd;
      logic [2:0]  rail;
      logic [2:0]  cond;
      logic [1:0]  pm_state;
      logic [2:0]  sub_state;
      logic [1:0]  scale;
      logic [7:0]  base_watts;
   } pbh_budget_word_t;

   typedef pbh_budget_word_t [BUDGET_WORDS-1:0] pbh_budget_table_t;

   typedef struct packed {
      logic [24:0] rsvd;
      logic        pvperl_long;
      logic        inband_pd;
      logic [1:0]  pepv_code;
      logic        turnoff_en;
      logic        l1_long;
      logic        l0s_long;
   } pbh_user_cfg_t;

   localparam pbh_user_cfg_t USER_CFG_RST = '{rsvd: '0, pvperl_long: 1'b1, inband_pd: 1'b0,
                                             pepv_code: 2'h0, turnoff_en: 1'b0, l1_long: 1'b0,
                                             l0s_long: 1'b0};

   // plain default figures; the integrator overrides them per board
   localparam pbh_budget_table_t BUDGET_RST = '{
      '{'0, RAIL_THERMAL, COND_MAX,     PM_D0, SUBSTATE_DEF, SCALE_0P1,   8'h3C},
      '{'0, RAIL_1V8,     COND_MAX,     PM_D0, SUBSTATE_DEF, SCALE_0P1,   8'h08},
      '{'0, RAIL_3V3,     COND_MAX,     PM_D0, SUBSTATE_DEF, SCALE_0P1,   8'h0C},
      '{'0, RAIL_12V,     COND_MAX,     PM_D0, SUBSTATE_DEF, SCALE_0P1,   8'h10},
      '{'0, RAIL_3V3,     COND_SUST,    PM_D0, SUBSTATE_DEF, SCALE_0P01,  8'h64},
      '{'0, RAIL_3V3,     COND_IDLE,    PM_D0, SUBSTATE_DEF, SCALE_0P01,  8'h32},
      '{'0, RAIL_3V3,     COND_AUX,     PM_D3, SUBSTATE_DEF, SCALE_0P001, 8'h14},
      '{'0, RAIL_3V3,     COND_PME_AUX, PM_D3, SUBSTATE_DEF, SCALE_1,     8'h00}};

   typedef enum logic [2:0] {
      PBH_OFF     = 3'h0,
      PBH_APPLY   = 3'h1,
      PBH_VALID   = 3'h3,
      PBH_RUN     = 3'h2,
      PBH_TURNOFF = 3'h6
   } pbh_slot_state_t;

endpackage

// ==== logic/pbh_power_budget_hotplug.sv ====
// power budget reporting and link-PM / hot-plug user configuration, Avalon-MM slave
// assumes all inputs synchronous to MCLK and a master that holds requests until waitrequest is low
//
// Contract
// [R1] data word bits 7:0 give base watts
// [R2] scale codes 0..3 give 1, .1, .01, .001
// [R3] sub-state field always reads zero
// [R4] power state field: 0 D0, 3 D3
// [R5] condition type codes 0,1,2,3,7 defined
// [R6] rail codes 12V, 3.3V, 1.8V, thermal
// [R7] allocation bit 0 marks budget already counted
// [R8] L0s after 1 or 4 us idle
// [R9] L1 needs upstream receiver idle 2/3 us
// [R10] turn-off message sent before port powers off
// [R11] power-valid delay 16/32/64/128 ms by code
// [R12] presence from pin or serdes receiver detect
// [R13] downstream reset released 20/100 ms after valid
// [R14] select index 0..7 picks the data word
// [R15] intervals are clock counters restarting on interruption
// [R16] data reads side-effect free, out-of-range reads zero
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pbh_power_budget_hotplug #(
   parameter int                         TMR_W            = pbh_pkg::TMR_W,
   parameter int                         PEPV_BASE_CYC    = pbh_pkg::PEPV_BASE_CYC,
   parameter int                         PVPERL_SHORT_CYC = pbh_pkg::PVPERL_SHORT_CYC,
   parameter int                         PVPERL_LONG_CYC  = pbh_pkg::PVPERL_LONG_CYC,
   parameter bit                         SYS_ALLOCATED    = 1'b0,
   parameter pbh_pkg::pbh_budget_table_t BUDGET_TABLE     = pbh_pkg::BUDGET_RST
) (
   input  wire logic                       MCLK,
   input  wire logic                       RST,
   input  wire logic [pbh_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input  wire logic                       AVS_READ,
   input  wire logic                       AVS_WRITE,
   input  wire logic [3:0]                 AVS_BYTEENABLE,
   input  wire logic [31:0]                AVS_WRITEDATA,
   output logic [31:0]                     AVS_READDATA,
   output logic                            AVS_WAITREQUEST,
   input  wire logic                       LINK_IDLE,
   input  wire logic                       UP_RX_IDLE,
   input  wire logic                       SLOT_PWR_REQ,
   input  wire logic                       SLOT_CARD_PRESENT_IN_N,
   input  wire logic                       SERDES_RX_DETECT,
   input  wire logic                       PME_TURN_OFF_SENT,
   output logic                            L0S_ENTER,
   output logic                            L1_READY,
   output logic                            CARD_PRESENT,
   output logic                            SLOT_PWR_EN,
   output logic                            SLOT_PWR_VALID,
   output logic                            DS_RESET_N,
   output logic                            PME_TURN_OFF_REQ
);

   // ****************************************
   // elaboration checks
   // ****************************************
   localparam longint MAX_CYC = longint'(PEPV_BASE_CYC) * 8;

   generate
      if (MAX_CYC >= (longint'(1) << TMR_W) || PVPERL_LONG_CYC >= (1 << TMR_W)) begin : g_bad_tmr
         $error("pbh_power_budget_hotplug: TMR_W too narrow for the delay counts");
      end
      if (PEPV_BASE_CYC < 1 || PVPERL_SHORT_CYC < 1 || PVPERL_LONG_CYC < 1) begin : g_bad_cyc
         $error("pbh_power_budget_hotplug: delay counts must be at least one cycle");
      end
   endgenerate

   // ****************************************
   // register bus
   // ****************************************
   pbh_pkg::pbh_user_cfg_t    cfg_ff;
   logic [7:0]                sel_ff;
   logic                      ack_ff;
   logic [31:0]               rdata_ff;
   logic [31:0]               nxt_rdata;
   pbh_pkg::pbh_budget_word_t budget_word;
   logic                      req;
   logic                      wr_go;
   logic [31:0]               status_word;

   assign req             = AVS_READ || AVS_WRITE;
   // one wait state: answer on the second cycle of every request
   assign AVS_WAITREQUEST = req && !ack_ff;
   assign wr_go           = AVS_WRITE && ack_ff;
   assign AVS_READDATA    = rdata_ff;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req && !ack_ff;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         sel_ff <= 8'h00;
      end else if (wr_go && AVS_ADDRESS == pbh_pkg::OFS_DATA_SEL && AVS_BYTEENABLE[0]) begin
         sel_ff <= AVS_WRITEDATA[7:0];  // see [R14]
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         cfg_ff <= pbh_pkg::USER_CFG_RST;
      end else if (wr_go && AVS_ADDRESS == pbh_pkg::OFS_USER_CFG && AVS_BYTEENABLE[0]) begin
         cfg_ff             <= '0;
         cfg_ff.l0s_long    <= AVS_WRITEDATA[0];
         cfg_ff.l1_long     <= AVS_WRITEDATA[1];
         cfg_ff.turnoff_en  <= AVS_WRITEDATA[2];
         cfg_ff.pepv_code   <= AVS_WRITEDATA[4:3];
         cfg_ff.inband_pd   <= AVS_WRITEDATA[5];
         cfg_ff.pvperl_long <= AVS_WRITEDATA[6];
      end
   end

   pbh_budget_table #(
      .N     (pbh_pkg::BUDGET_WORDS),
      .TABLE (BUDGET_TABLE)
   ) u_table (
      .sel  (sel_ff),
      .word (budget_word)
   );

   // ****************************************
   // read mux
   // ****************************************
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (AVS_ADDRESS)
         pbh_pkg::OFS_DATA_SEL: nxt_rdata = {24'h00_0000, sel_ff};
         pbh_pkg::OFS_DATA:     nxt_rdata = budget_word;  // see [R1] [R2] [R3] [R4] [R5] [R6] [R16]
         pbh_pkg::OFS_ALLOC:    nxt_rdata = {31'h0000_0000, SYS_ALLOCATED};  // see [R7]
         pbh_pkg::OFS_USER_CFG: nxt_rdata = cfg_ff;
         pbh_pkg::OFS_STATUS:   nxt_rdata = status_word;
         default:               nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         rdata_ff <= 32'h0000_0000;
      end else if (AVS_READ && !ack_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************
   // link power management idle timers
   // ****************************************
   logic [TMR_W-1:0] l0s_limit;
   logic [TMR_W-1:0] l1_limit;
   logic             l0s_done;
   logic             l1_done;
   logic             l0s_ff;
   logic             l1_ff;

   assign l0s_limit = cfg_ff.l0s_long ? TMR_W'(pbh_pkg::L0S_LONG_CYC)
                                      : TMR_W'(pbh_pkg::L0S_SHORT_CYC);  // see [R8]
   assign l1_limit  = cfg_ff.l1_long  ? TMR_W'(pbh_pkg::L1_LONG_CYC)
                                      : TMR_W'(pbh_pkg::L1_SHORT_CYC);   // see [R9]

   pbh_interval_timer #(.W(TMR_W)) u_l0s_tmr (
      .clk   (MCLK),
      .rst   (RST),
      .run   (LINK_IDLE),
      .limit (l0s_limit),
      .done  (l0s_done)
   );  // see [R15]

   pbh_interval_timer #(.W(TMR_W)) u_l1_tmr (
      .clk   (MCLK),
      .rst   (RST),
      .run   (UP_RX_IDLE),
      .limit (l1_limit),
      .done  (l1_done)
   );  // see [R15]

   always_ff @(posedge MCLK) begin
      if (RST) begin
         l0s_ff <= 1'b0;
         l1_ff  <= 1'b0;
      end else begin
         l0s_ff <= l0s_done;
         l1_ff  <= l1_done;
      end
   end

   assign L0S_ENTER = l0s_ff;
   assign L1_READY  = l1_ff;

   // ****************************************
   // slot power manager
   // ****************************************
   pbh_pkg::pbh_slot_state_t state_ff;
   pbh_pkg::pbh_slot_state_t nxt_state;
   logic [TMR_W-1:0]         pepv_limit;
   logic [TMR_W-1:0]         pvperl_limit;
   logic                     pepv_done;
   logic                     pvperl_done;
   logic                     present;
   logic                     leave;
   logic                     pwr_en_ff;
   logic                     pwr_valid_ff;
   logic                     rst_n_ff;
   logic                     turnoff_ff;

   // pin is active low; serdes detect is only trusted when selected
   assign present      = cfg_ff.inband_pd ? SERDES_RX_DETECT : !SLOT_CARD_PRESENT_IN_N;  // see [R12]
   assign CARD_PRESENT = present;
   assign leave        = !SLOT_PWR_REQ || !present;
   assign pepv_limit   = TMR_W'(PEPV_BASE_CYC) << cfg_ff.pepv_code;  // see [R11]
   assign pvperl_limit = cfg_ff.pvperl_long ? TMR_W'(PVPERL_LONG_CYC)
                                            : TMR_W'(PVPERL_SHORT_CYC);  // see [R13]

   pbh_interval_timer #(.W(TMR_W)) u_pepv_tmr (
      .clk   (MCLK),
      .rst   (RST),
      .run   (state_ff == pbh_pkg::PBH_APPLY),
      .limit (pepv_limit),
      .done  (pepv_done)
   );  // see [R15]

   pbh_interval_timer #(.W(TMR_W)) u_pvperl_tmr (
      .clk   (MCLK),
      .rst   (RST),
      .run   (state_ff == pbh_pkg::PBH_VALID),
      .limit (pvperl_limit),
      .done  (pvperl_done)
   );  // see [R15]

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         pbh_pkg::PBH_OFF: begin
            if (SLOT_PWR_REQ && present) begin
               nxt_state = pbh_pkg::PBH_APPLY;
            end
         end
         pbh_pkg::PBH_APPLY: begin
            if (leave) begin
               nxt_state = pbh_pkg::PBH_OFF;
            end else if (pepv_done) begin
               nxt_state = pbh_pkg::PBH_VALID;  // see [R11]
            end
         end
         pbh_pkg::PBH_VALID: begin
            if (leave) begin
               nxt_state = pbh_pkg::PBH_OFF;
            end else if (pvperl_done) begin
               nxt_state = pbh_pkg::PBH_RUN;  // see [R13]
            end
         end
         pbh_pkg::PBH_RUN: begin
            if (leave) begin
               // link is up only here, so only here can the message go out
               nxt_state = cfg_ff.turnoff_en ? pbh_pkg::PBH_TURNOFF : pbh_pkg::PBH_OFF;  // see [R10]
            end
         end
         pbh_pkg::PBH_TURNOFF: begin
            if (PME_TURN_OFF_SENT) begin
               nxt_state = pbh_pkg::PBH_OFF;  // see [R10]
            end
         end
         default: nxt_state = pbh_pkg::PBH_OFF;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         state_ff <= pbh_pkg::PBH_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // outputs registered from the next state so they change with the state
   always_ff @(posedge MCLK) begin
      if (RST) begin
         pwr_en_ff    <= 1'b0;
         pwr_valid_ff <= 1'b0;
         rst_n_ff     <= 1'b0;
         turnoff_ff   <= 1'b0;
      end else begin
         pwr_en_ff    <= nxt_state != pbh_pkg::PBH_OFF;
         pwr_valid_ff <= nxt_state == pbh_pkg::PBH_VALID || nxt_state == pbh_pkg::PBH_RUN
                         || nxt_state == pbh_pkg::PBH_TURNOFF;
         rst_n_ff     <= nxt_state == pbh_pkg::PBH_RUN || nxt_state == pbh_pkg::PBH_TURNOFF;
         turnoff_ff   <= nxt_state == pbh_pkg::PBH_TURNOFF;
      end
   end

   assign SLOT_PWR_EN      = pwr_en_ff;
   assign SLOT_PWR_VALID   = pwr_valid_ff;
   assign DS_RESET_N       = rst_n_ff;
   assign PME_TURN_OFF_REQ = turnoff_ff;
   assign status_word      = {24'h00_0000, turnoff_ff, rst_n_ff, pwr_valid_ff, pwr_en_ff,
                              present, l1_ff, l0s_ff, 1'b0};

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   a_data_range: assert property (AVS_READ && ack_ff && AVS_ADDRESS == pbh_pkg::OFS_DATA && sel_ff > 8'h07
                                  |-> AVS_READDATA == 32'h0000_0000)  // see [R16]
      else $error("out-of-range budget read not zero");
   a_data_select: assert property (AVS_READ && ack_ff && AVS_ADDRESS == pbh_pkg::OFS_DATA && sel_ff < 8'h08
                                   |-> AVS_READDATA[7:0] == BUDGET_TABLE[sel_ff[2:0]].base_watts
                                       && AVS_READDATA[9:8] == BUDGET_TABLE[sel_ff[2:0]].scale)  // see [R14]
      else $error("budget word does not match index");
   a_sub_state: assert property (AVS_READ && ack_ff && AVS_ADDRESS == pbh_pkg::OFS_DATA
                                 |-> AVS_READDATA[12:10] == 3'h0)  // see [R3]
      else $error("sub-state field not zero");
   a_one_wait: assert property (req && !ack_ff |=> !AVS_WAITREQUEST || !req)
      else $error("bus answer not on second cycle");
   a_l0s_short: assert property ($rose(L0S_ENTER) && !cfg_ff.l0s_long && $stable(cfg_ff)
                                 |-> $past(LINK_IDLE, 41) || $past(LINK_IDLE, 40))  // see [R8]
      else $error("L0s entered before idle time");
   a_l0s_drop: assert property (!LINK_IDLE |=> !L0S_ENTER)  // see [R15]
      else $error("L0s held after idle ended");
   a_l1_hold: assert property (L1_READY |-> $past(UP_RX_IDLE))  // see [R9]
      else $error("L1 ready without receiver idle");
   a_presence: assert property (CARD_PRESENT == (cfg_ff.inband_pd ? SERDES_RX_DETECT
                                                                  : !SLOT_CARD_PRESENT_IN_N))  // see [R12]
      else $error("presence source wrong");
   a_reset_order: assert property (DS_RESET_N |-> SLOT_PWR_VALID && SLOT_PWR_EN)  // see [R13]
      else $error("reset released without valid power");
   a_turnoff_msg: assert property (state_ff == pbh_pkg::PBH_RUN && leave && cfg_ff.turnoff_en
                                   |=> PME_TURN_OFF_REQ && SLOT_PWR_EN)  // see [R10]
      else $error("power removed without turn-off message");
   a_valid_wait: assert property ($rose(SLOT_PWR_VALID) |-> $past(SLOT_PWR_EN, 2))  // see [R11]
      else $error("power valid without applied power");

   c_l0s: cover property ($rose(L0S_ENTER));
   c_reset_release: cover property ($rose(DS_RESET_N));
   c_turnoff: cover property (PME_TURN_OFF_REQ ##1 !SLOT_PWR_EN);
   c_oor_read: cover property (AVS_READ && ack_ff && AVS_ADDRESS == pbh_pkg::OFS_DATA && sel_ff > 8'h07);

endmodule // pbh_power_budget_hotplug
`default_nettype wire

// ==== verification/pbh_power_budget_hotplug_tb.sv ====
// self-checking bench for the power budget / hot-plug block
// assumes shortened slot timers; link-PM counts use the package figures
`timescale 1ns/1ps
`default_nettype none
module pbh_power_budget_hotplug_tb;
   // ****************************************
   // stimulus and wiring
   // ****************************************
   logic MCLK = 0, RST = 1, rd = 0, wr = 0, lidle = 0, uidle = 0, preq = 0, card = 0;
   logic [8:0]  addr = '0;
   logic [31:0] wd = '0, rv, rdata, c;
   logic        wreq, l0s, l1r, cp, pen, pval, dsrn, toreq, pin_n, rxd, sent;
   int          err_count = 0, check_count = 0, cyc = 0;
   always #12.5 MCLK = ~MCLK;
   pbh_power_budget_hotplug #(.PEPV_BASE_CYC(20), .PVPERL_SHORT_CYC(10), .PVPERL_LONG_CYC(30),
      .SYS_ALLOCATED(1'b1)) u_pbh_power_budget_hotplug (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .LINK_IDLE(lidle), .UP_RX_IDLE(uidle), .SLOT_PWR_REQ(preq),
      .SLOT_CARD_PRESENT_IN_N(pin_n), .SERDES_RX_DETECT(rxd), .PME_TURN_OFF_SENT(sent), .L0S_ENTER(l0s),
      .L1_READY(l1r), .CARD_PRESENT(cp), .SLOT_PWR_EN(pen), .SLOT_PWR_VALID(pval), .DS_RESET_N(dsrn),
      .PME_TURN_OFF_REQ(toreq));
   pbh_slot_partner u_pbh_slot_partner (.clk(MCLK), .rst(RST), .card_in(card), .pwr_en(pen),
      .turnoff_req(toreq), .card_pin_n(pin_n), .rx_detect(rxd), .turnoff_sent(sent));
   // ****************************************
   // tasks
   // ****************************************
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      @(posedge MCLK);
      rd <= !w; wr <= w; addr <= a; wd <= d;
      // sampled before the edge's own updates land, so these are the values standing at the edge
      do @(posedge MCLK); while (wreq !== 1'b0);
      rv = rdata;
      rd <= 1'b0; wr <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [8:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk(nm, rv, e);
   endtask
   function automatic logic probe(int s);
      case (s)
         0: return l0s;
         1: return l1r;
         2: return pval;
         3: return dsrn;
         default: return !pen;
      endcase
   endfunction
   // k ends as the cycle index of the rise, one cycle of slack each way
   task automatic span(input string nm, input int s, input int e);
      int k;
      k = 0;
      do begin @(negedge MCLK); k++; end while (probe(s) !== 1'b1 && k < 5000);
      chk(nm, 32'(k >= e - 1 && k <= e + 1), 32'h00000001);
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (8) @(posedge MCLK);
      RST <= 1'b0;
      rchk("user_cfg", 9'h1E0, 32'h00000040);
      rchk("alloc", 9'h144, 32'h00000001);
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, 9'h13C, 32'(i));
         rchk("select", 9'h13C, 32'(i));
         c = (i < 8) ? pbh_pkg::BUDGET_RST[i[2:0]] : 32'h00000000;
         c[12:10] = 3'h0;
         rchk("budget", 9'h140, c);
         rchk("budget_again", 9'h140, c);
      end
      // an in-range index, so an accepted write to the data word would show
      bus(1'b1, 9'h13C, 32'h00000002);
      bus(1'b1, 9'h140, 32'hFFFFFFFF);
      rchk("budget_ro", 9'h140, pbh_pkg::BUDGET_RST[2]);
      bus(1'b1, 9'h144, 32'h00000000);
      rchk("alloc_ro", 9'h144, 32'h00000001);
      rchk("unmapped", 9'h100, 32'h00000000);
      for (int m = 0; m < 4; m += 3) begin
         bus(1'b1, 9'h1E0, 32'(m));
         @(posedge MCLK); lidle <= 1'b1;
         @(negedge MCLK) span("l0s_time", 0, m[0] ? 161 : 41);
         @(posedge MCLK); lidle <= 1'b0; uidle <= 1'b1;
         @(negedge MCLK) span("l1_time", 1, m[1] ? 121 : 81);
         @(posedge MCLK); uidle <= 1'b0;
      end
      bus(1'b1, 9'h1E0, 32'h00000000);
      @(posedge MCLK); lidle <= 1'b1;
      repeat (30) @(posedge MCLK);
      lidle <= 1'b0;
      @(posedge MCLK); lidle <= 1'b1;
      @(negedge MCLK) span("l0s_restart", 0, 41);
      @(posedge MCLK); lidle <= 1'b0; card <= 1'b1;
      @(negedge MCLK) chk("present_pin", cp, 32'h00000001);
      bus(1'b1, 9'h1E0, 32'h00000020);
      @(negedge MCLK) chk("present_rx", cp, 32'h00000000);
      for (int k = 0; k < 4; k++) begin
         c = {25'h0, k[0], 1'b0, k[1:0], (k == 3), 2'b00};
         bus(1'b1, 9'h1E0, c);
         @(posedge MCLK); preq <= 1'b1;
         @(negedge MCLK) span("pwr_valid", 2, (20 << k) + 2);
         span("ds_reset", 3, k[0] ? 31 : 11);
         rchk("status", 9'h1E4, 32'h00000078);
         @(posedge MCLK); preq <= 1'b0;
         repeat (2) @(negedge MCLK);
         chk("leave", {toreq, pen, dsrn}, (k == 3) ? 3'b111 : 3'b000);
         // without the message, power is already gone at the first look
         span("off", 4, (k == 3) ? 6 : 1);
      end
      chk("turnoff_done", toreq, 32'h00000000);
      close_out();
   end
endmodule // pbh_power_budget_hotplug_tb
`default_nettype wire

// ==== verification/pbh_slot_partner.sv ====
// slot and link partner model: presence pin, receiver detect, turn-off reply
// assumes one clock shared with the block under test
`timescale 1ns/1ps
`default_nettype none
module pbh_slot_partner #(
   parameter int REPLY_CYC = 5
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic card_in,
   input  wire logic pwr_en,
   input  wire logic turnoff_req,
   output logic      card_pin_n,
   output logic      rx_detect,
   output logic      turnoff_sent
);
   // ****************************************
   // slot model
   // ****************************************
   int wait_ff;
   // pulled up, so an empty slot reads high
   assign card_pin_n = !card_in;
   // unpowered receivers show no termination, so detect needs slot power
   assign rx_detect = card_in & pwr_en;
   always_ff @(posedge clk) begin
      if (rst || !turnoff_req) wait_ff <= 0;
      else if (wait_ff <= REPLY_CYC) wait_ff <= wait_ff + 1;
   end
   // a slow reply, so power must be seen to stay up meanwhile
   assign turnoff_sent = (wait_ff == REPLY_CYC);
endmodule // pbh_slot_partner
`default_nettype wire
